// ===== hw/mfr_status_consts.vh
// Purpose: constants for the status and telemetry readback bank
// Assumes: eight channels, command codes chosen locally
// Notes: definitions only
`ifndef MFR_STATUS_CONSTS_VH
`define MFR_STATUS_CONSTS_VH
`define NUM_CHAN 8
`define PAGE_W 3
`define CMD_W 8
`define CMD_MFR_STATUS 8'h80
`define CMD_READ_VIN 8'h88
`define CMD_READ_VOUT 8'h8B
`define CMD_READ_TEMP 8'h8D
`define CMD_REVISION 8'h98
`define REVISION_VALUE 8'h11
`define BIT_DISCHARGE 7
`define BIT_FAULT_ONE 6
`define BIT_FAULT_ZERO 5
`define BIT_SERVO_REACHED 4
`define BIT_DAC_CONNECTED 3
`define BIT_DAC_SATURATED 2
`define BIT_VINEN_OFF 1
`define BIT_WATCHDOG 0
`define STICKY_RESET 4'h0
`define WORD_RESET 16'h0000
`endif

// ===== hw/chan_sticky_flags.v
// Purpose: sticky per-channel status flags
// Assumes: events are single-cycle or level, same clock
// Notes: set wins over clear
`timescale 1ns/1ns
`default_nettype none
`include "mfr_status_consts.vh"
module chan_sticky_flags (
    input wire clk,
    input wire rst_n,
    input wire set_discharge,
    input wire set_fault_one,
    input wire set_fault_zero,
    input wire set_saturated,
    input wire clear_all,
    input wire clear_fault_lines,
    output reg [3:0] flags_ff
);
    reg [3:0] nxt_flags_ff;
    always @* begin
        nxt_flags_ff = flags_ff;
        if (clear_all) begin
            nxt_flags_ff = 4'h0;
        end
        if (clear_fault_lines) begin
            nxt_flags_ff[2:1] = 2'h0;
        end
        // Set after clear so a coincident event is kept
        if (set_discharge) nxt_flags_ff[3] = 1'b1;
        if (set_fault_one) nxt_flags_ff[2] = 1'b1;
        if (set_fault_zero) nxt_flags_ff[1] = 1'b1;
        if (set_saturated) nxt_flags_ff[0] = 1'b1;
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_ff <= `STICKY_RESET;
        end else begin
            flags_ff <= nxt_flags_ff;
        end
    end
endmodule // chan_sticky_flags
`default_nettype wire

// ===== hw/telemetry_store.v
// Purpose: latest ADC result words, one per channel
// Assumes: one write port from the ADC sequencer
// Notes: read data registered
`timescale 1ns/1ns
`default_nettype none
`include "mfr_status_consts.vh"
module telemetry_store (
    input wire clk,
    input wire rst_n,
    input wire wr_en,
    input wire [2:0] wr_addr,
    input wire [15:0] wr_data,
    input wire [2:0] rd_addr,
    output reg [15:0] rd_data_ff
);
    reg [15:0] mem_ff [0:7];
    genvar i;
    generate
        for (i = 0; i < `NUM_CHAN; i = i + 1) begin : g_word
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_ff[i] <= `WORD_RESET;
                end else if (wr_en && wr_addr == i) begin
                    mem_ff[i] <= wr_data;
                end
            end
        end
    endgenerate
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= `WORD_RESET;
        end else begin
            rd_data_ff <= mem_ff[rd_addr];
        end
    end
endmodule // telemetry_store
`default_nettype wire

// ===== hw/mfr_status_telemetry.v
// Purpose: status byte and telemetry readback for an eight-channel supply manager
// Assumes: command decoder presents cmd_code and page; read data two cycles later
// Notes: status events come from sequencer, servo, DAC and watchdog logic
// Function
// - Non-paged bits identical on every page
// - Sticky bits clear by clear-faults; channel bits also by turn-on
// - Alert-enabled bit set pulls alert low
// - Discharge, fault-line events may turn off
// - Bit 7 discharge fault, sticky, alerting
// - Bits 6,5 fault-line events, sticky, alerting
// - Fault-line flags cleared by control/operation cycles
// - Bit 4 live servo target reached
// - Bit 3 live DAC connected
// - Bit 2 DAC saturated, sticky, no alert
// - Bit 1 live input-enable faulted off
// - Bit 0 watchdog fault, sticky, alerting
// - Input voltage word, L11 volts
// - Output word per channel, L16 volts
// - Odd hires channel output, L11 millivolts
// - Temperature word, L11 Celsius
// - Revision byte constant read-only
`timescale 1ns/1ns
`default_nettype none
`include "mfr_status_consts.vh"
module mfr_status_telemetry (
    input wire clk,
    input wire rst_n,
    input wire [2:0] page,
    input wire rd_req,
    input wire [7:0] cmd_code,
    input wire clear_faults,
    input wire [7:0] chan_turn_on,
    input wire [7:0] control_pin_toggle,
    input wire [7:0] operation_on_off_cycle,
    input wire [7:0] discharge_fault_evt,
    input wire [7:0] turn_on_attempt,
    input wire [7:0] fault_shutdown_one,
    input wire [7:0] fault_shutdown_zero,
    input wire shared_fault_line_one_n,
    input wire shared_fault_line_zero_n,
    input wire [7:0] servo_target_reached,
    input wire [7:0] dac_connected,
    input wire [7:0] servo_done_saturated,
    input wire vin_en_faulted_off,
    input wire watchdog_fault_evt,
    input wire [7:0] adc_hires_cfg,
    input wire vin_wr,
    input wire [15:0] vin_l11,
    input wire vout_wr,
    input wire [2:0] vout_chan,
    input wire [15:0] vout_word,
    input wire temp_wr,
    input wire [15:0] temp_l11,
    output reg [15:0] rd_data_ff,
    output reg rd_valid_ff,
    output reg rd_unknown_ff,
    output reg rd_vout_is_l11_ff,
    output reg host_alert_out_n_o_ff,
    output reg host_alert_out_n_oe_ff,
    output reg [7:0] turn_off_req_ff
);
    // Fault lines from pins: three flops, change taken when stages 2 and 3 agree
    reg [1:0] sync1_ff;
    reg [1:0] sync2_ff;
    reg [1:0] sync3_ff;
    reg [1:0] line_low_ff;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= 2'h3;
            sync2_ff <= 2'h3;
            sync3_ff <= 2'h3;
            line_low_ff <= 2'h0;
        end else begin
            sync1_ff <= {shared_fault_line_one_n, shared_fault_line_zero_n};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            if (sync2_ff[0] == sync3_ff[0]) line_low_ff[0] <= ~sync3_ff[0];
            if (sync2_ff[1] == sync3_ff[1]) line_low_ff[1] <= ~sync3_ff[1];
        end
    end

    wire [3:0] sticky [0:7];
    wire [7:0] alert_chan;
    genvar c;
    generate
        for (c = 0; c < `NUM_CHAN; c = c + 1) begin : g_chan
            chan_sticky_flags u_flags (
                .clk(clk),
                .rst_n(rst_n),
                .set_discharge(discharge_fault_evt[c]),
                .set_fault_one((turn_on_attempt[c] & line_low_ff[1]) |
                    fault_shutdown_one[c]),
                .set_fault_zero((turn_on_attempt[c] & line_low_ff[0]) |
                    fault_shutdown_zero[c]),
                .set_saturated(servo_done_saturated[c]),
                .clear_all(clear_faults | chan_turn_on[c]),
                .clear_fault_lines(control_pin_toggle[c] |
                    operation_on_off_cycle[c]),
                .flags_ff(sticky[c])
            );
            // Saturated flag is excluded from alert
            assign alert_chan[c] = |sticky[c][3:1];
        end
    endgenerate

    // Watchdog flag is chip-wide, not paged
    reg watchdog_ff;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_ff <= 1'b0;
        end else if (watchdog_fault_evt) begin
            watchdog_ff <= 1'b1;
        end else if (clear_faults) begin
            watchdog_ff <= 1'b0;
        end
    end

    // Turn-off requests only from discharge and fault-line events
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            turn_off_req_ff <= 8'h00;
        end else begin
            turn_off_req_ff <= discharge_fault_evt |
                (turn_on_attempt & {8{|line_low_ff}}) |
                fault_shutdown_one | fault_shutdown_zero;
        end
    end

    // Open-drain alert: drive low while any alerting flag is set
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            host_alert_out_n_o_ff <= 1'b1;
            host_alert_out_n_oe_ff <= 1'b0;
        end else begin
            host_alert_out_n_o_ff <= 1'b0;
            host_alert_out_n_oe_ff <= (|alert_chan) | watchdog_ff;
        end
    end

    reg [15:0] vin_ff;
    reg [15:0] temp_ff;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vin_ff <= `WORD_RESET;
            temp_ff <= `WORD_RESET;
        end else begin
            if (vin_wr) vin_ff <= vin_l11;
            if (temp_wr) temp_ff <= temp_l11;
        end
    end

    wire [15:0] vout_rd;
    telemetry_store u_vout (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(vout_wr),
        .wr_addr(vout_chan),
        .wr_data(vout_word),
        .rd_addr(page),
        .rd_data_ff(vout_rd)
    );

    // Store answers one cycle late, so hold the command for the mux
    reg pend_ff;
    reg [7:0] pend_cmd_ff;
    reg [2:0] pend_page_ff;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_ff <= 1'b0;
            pend_cmd_ff <= 8'h00;
            pend_page_ff <= 3'h0;
        end else begin
            pend_ff <= rd_req;
            pend_cmd_ff <= cmd_code;
            pend_page_ff <= page;
        end
    end

    wire [3:0] sel_sticky = sticky[pend_page_ff];
    // Bit positions come from the header so the layout lives in one place
    reg [7:0] status_byte;
    always @* begin
        status_byte = 8'h00;
        status_byte[`BIT_DISCHARGE] = sel_sticky[3];
        status_byte[`BIT_FAULT_ONE] = sel_sticky[2];
        status_byte[`BIT_FAULT_ZERO] = sel_sticky[1];
        status_byte[`BIT_SERVO_REACHED] = servo_target_reached[pend_page_ff];
        status_byte[`BIT_DAC_CONNECTED] = dac_connected[pend_page_ff];
        status_byte[`BIT_DAC_SATURATED] = sel_sticky[0];
        // Chip-wide bits ignore the page
        status_byte[`BIT_VINEN_OFF] = vin_en_faulted_off;
        status_byte[`BIT_WATCHDOG] = watchdog_ff;
    end
    wire odd_hires = pend_page_ff[0] & adc_hires_cfg[pend_page_ff];

    // Reads only select; nothing is cleared on read
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= `WORD_RESET;
            rd_valid_ff <= 1'b0;
            rd_unknown_ff <= 1'b0;
            rd_vout_is_l11_ff <= 1'b0;
        end else begin
            rd_valid_ff <= pend_ff;
            rd_unknown_ff <= 1'b0;
            rd_vout_is_l11_ff <= 1'b0;
            if (pend_ff) begin
                case (pend_cmd_ff)
                    `CMD_MFR_STATUS: rd_data_ff <= {8'h00, status_byte};
                    `CMD_READ_VIN: rd_data_ff <= vin_ff;
                    `CMD_READ_VOUT: begin
                        rd_data_ff <= vout_rd;
                        rd_vout_is_l11_ff <= odd_hires;
                    end
                    `CMD_READ_TEMP: rd_data_ff <= temp_ff;
                    `CMD_REVISION: rd_data_ff <= {8'h00, `REVISION_VALUE};
                    default: begin
                        rd_data_ff <= `WORD_RESET;
                        rd_unknown_ff <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule // mfr_status_telemetry
`default_nettype wire

// ===== tb/alert_pullup_host.sv
// Purpose: host side of the open-drain alert line
// Assumes: host holds a pull-up on the line
// Notes: line floats high unless the device pulls
`timescale 1ns/1ns
`default_nettype none
module alert_pullup_host (
    input wire logic host_alert_out_n_o_ff,
    input wire logic host_alert_out_n_oe_ff,
    output wire logic alert_wire_n
);
    // Pull-up wins whenever the device lets go
    assign alert_wire_n = host_alert_out_n_oe_ff ? host_alert_out_n_o_ff : 1'b1;
endmodule // alert_pullup_host
`default_nettype wire

// ===== tb/mfr_status_assertions.sv
// Purpose: port-level checks of the status bank
// Assumes: single clock, async reset
// Notes: bound to the top module
`timescale 1ns/1ns
`default_nettype none
`include "mfr_status_consts.vh"
module mfr_status_checker (
    input wire clk,
    input wire rst_n,
    input wire [2:0] page,
    input wire rd_req,
    input wire [7:0] cmd_code,
    input wire [7:0] discharge_fault_evt,
    input wire [7:0] turn_on_attempt,
    input wire [7:0] fault_shutdown_one,
    input wire [7:0] fault_shutdown_zero,
    input wire watchdog_fault_evt,
    input wire [7:0] adc_hires_cfg,
    input wire [15:0] rd_data_ff,
    input wire rd_valid_ff,
    input wire rd_unknown_ff,
    input wire rd_vout_is_l11_ff,
    input wire host_alert_out_n_oe_ff,
    input wire [7:0] turn_off_req_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_RD_LAT: assert property (rd_req |-> ##2 rd_valid_ff)
        else $error("read answer not two cycles later");
    AST_NO_SPURIOUS: assert property (rd_valid_ff |-> $past(rd_req, 2))
        else $error("answer without a request");
    AST_UNK_ZERO: assert property (rd_unknown_ff
        |-> rd_valid_ff && rd_data_ff == 16'h0000)
        else $error("unknown command answered with data");
    AST_REV: assert property (rd_req && cmd_code == `CMD_REVISION
        |-> ##2 rd_data_ff == 16'h0011)
        else $error("revision byte wrong");
    AST_STAT_HI: assert property (rd_req && cmd_code == `CMD_MFR_STATUS
        |-> ##2 rd_data_ff[15:8] == 8'h00)
        else $error("status upper byte not zero");
    AST_L11: assert property (rd_req && cmd_code == `CMD_READ_VOUT
        |-> ##2 rd_vout_is_l11_ff == $past(page[0] && adc_hires_cfg[page], 2))
        else $error("output word format flag wrong");
    AST_DIS_ALERT: assert property (|discharge_fault_evt |-> ##2 host_alert_out_n_oe_ff)
        else $error("discharge fault did not pull alert");
    AST_WD_ALERT: assert property (watchdog_fault_evt |-> ##2 host_alert_out_n_oe_ff)
        else $error("watchdog fault did not pull alert");
    AST_DIS_OFF: assert property (|discharge_fault_evt
        |=> (turn_off_req_ff & $past(discharge_fault_evt)) == $past(discharge_fault_evt))
        else $error("discharge fault gave no turn-off request");
    AST_NO_OFF: assert property (
        !(|{discharge_fault_evt, turn_on_attempt, fault_shutdown_one, fault_shutdown_zero})
        |=> turn_off_req_ff == 8'h00)
        else $error("turn-off request without a cause");
    AST_FLT_OFF: assert property (|(fault_shutdown_one | fault_shutdown_zero)
        |=> (turn_off_req_ff & $past(fault_shutdown_one | fault_shutdown_zero))
        == $past(fault_shutdown_one | fault_shutdown_zero))
        else $error("fault-line shutdown gave no turn-off request");
    AST_FLT_ALERT: assert property (|(fault_shutdown_one | fault_shutdown_zero)
        |-> ##2 host_alert_out_n_oe_ff)
        else $error("fault-line flag did not pull alert");
    cover property (rd_unknown_ff);
    cover property ($rose(host_alert_out_n_oe_ff));
    cover property (rd_vout_is_l11_ff);
endmodule // mfr_status_checker
bind mfr_status_telemetry mfr_status_checker chk (.*);
`default_nettype wire

// ===== tb/mfr_status_telemetry_test.sv
// Purpose: self-checking bench for the status and telemetry bank
// Assumes: inputs change 1 ns after the rising edge
// Notes: reads queue their expectation; a monitor checks each answer
`timescale 1ns/1ns
`default_nettype none
`include "mfr_status_consts.vh"
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
`define PULSE(s, v) s = v; @(posedge clk); #1 s = 0; @(posedge clk); #1
module mfr_status_telemetry_test;
    logic clk = 0, rst_n = 0, rd_req = 0, clear_faults = 0, vin_en_faulted_off = 0;
    logic watchdog_fault_evt = 0, vin_wr = 0, vout_wr = 0, temp_wr = 0, wd = 0;
    logic shared_fault_line_one_n = 1, shared_fault_line_zero_n = 1;
    logic [2:0] page = 0, vout_chan = 0;
    logic [7:0] cmd_code = 0, chan_turn_on = 0, control_pin_toggle = 0;
    logic [7:0] operation_on_off_cycle = 0, discharge_fault_evt = 0, turn_on_attempt = 0;
    logic [7:0] fault_shutdown_one = 0, fault_shutdown_zero = 0, servo_target_reached = 0;
    logic [7:0] dac_connected = 0, servo_done_saturated = 0, adc_hires_cfg = 0;
    logic [15:0] vin_l11 = 0, vout_word = 0, temp_l11 = 0, rd_data_ff;
    logic rd_valid_ff, rd_unknown_ff, rd_vout_is_l11_ff, host_alert_out_n_o_ff;
    logic host_alert_out_n_oe_ff, alert_wire_n;
    logic [7:0] turn_off_req_ff;
    logic [7:0] stk [8];
    logic [15:0] vo [8];
    logic [17:0] q [$];
    logic [17:0] got;
    int err_total = 0, num_checks = 0, cyc = 0;
    mfr_status_telemetry dut (.*);
    alert_pullup_host host (.host_alert_out_n_o_ff, .host_alert_out_n_oe_ff, .alert_wire_n);
    initial forever #4 clk = ~clk;
    task automatic conclude;
        if (err_total == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end
    // Sample mid-cycle so registered answers have settled
    always @(negedge clk) if (rd_valid_ff === 1'b1) begin
        got = q.pop_front();
        `CHK("read", got, {rd_unknown_ff, rd_vout_is_l11_ff, rd_data_ff})
    end
    function automatic logic [17:0] st(input int p);
        st = {10'h000, stk[p] | {3'b000, servo_target_reached[p], dac_connected[p], 1'b0,
            vin_en_faulted_off, wd}};
    endfunction
    task automatic rd(input logic [7:0] c, input int p, input logic [17:0] e);
        rd_req = 1;
        cmd_code = c;
        page = 3'(p);
        q.push_back(e);
        @(posedge clk);
        #1 rd_req = 0;
        @(posedge clk);
        #1;
    endtask
    initial begin
        for (int i = 0; i < 8; i++) stk[i] = 8'h00;
        void'($urandom(32'hCE9DB08B));
        repeat (16) @(posedge clk);
        #1 rst_n = 1;
        @(posedge clk);
        #1;
        `CHK("alert idle", 1'b1, alert_wire_n)
        rd(`CMD_REVISION, 5, 18'h00011);
        rd(8'h00, 0, 18'h20000);
        vin_l11 = 16'($urandom);
        temp_l11 = 16'($urandom);
        adc_hires_cfg = 8'($urandom) | 8'h02;
        vin_wr = 1;
        temp_wr = 1;
        @(posedge clk);
        #1 vin_wr = 0;
        temp_wr = 0;
        vout_wr = 1;
        for (int i = 0; i < 8; i++) begin
            vout_chan = 3'(i);
            vo[i] = 16'($urandom);
            vout_word = vo[i];
            @(posedge clk);
            #1;
        end
        vout_wr = 0;
        rd(`CMD_READ_VIN, 0, {2'b00, vin_l11});
        rd(`CMD_READ_TEMP, 7, {2'b00, temp_l11});
        for (int i = 0; i < 8; i++) begin
            rd(`CMD_READ_VOUT, i, {1'b0, i[0] & adc_hires_cfg[i], vo[i]});
        end
        servo_target_reached = 8'($urandom);
        dac_connected = 8'($urandom);
        vin_en_faulted_off = 1;
        `PULSE(discharge_fault_evt, 8'h04);
        stk[2][7] = 1;
        rd(`CMD_MFR_STATUS, 2, st(2));
        rd(`CMD_MFR_STATUS, 2, st(2));
        rd(`CMD_MFR_STATUS, 3, st(3));
        `CHK("alert low", 1'b0, alert_wire_n)
        `PULSE(chan_turn_on, 8'h04);
        stk[2] = 8'h00;
        rd(`CMD_MFR_STATUS, 2, st(2));
        shared_fault_line_one_n = 0;
        shared_fault_line_zero_n = 0;
        repeat (5) @(posedge clk);
        #1;
        `PULSE(turn_on_attempt, 8'h02);
        `PULSE(fault_shutdown_zero, 8'h10);
        `PULSE(servo_done_saturated, 8'h40);
        shared_fault_line_one_n = 1;
        shared_fault_line_zero_n = 1;
        stk[1] = 8'h60;
        stk[4] = 8'h20;
        stk[6] = 8'h04;
        for (int i = 1; i < 7; i++) rd(`CMD_MFR_STATUS, i, st(i));
        `PULSE(control_pin_toggle, 8'h02);
        `PULSE(operation_on_off_cycle, 8'h10);
        stk[1] = 8'h00;
        stk[4] = 8'h00;
        for (int i = 1; i < 7; i++) rd(`CMD_MFR_STATUS, i, st(i));
        `CHK("alert sat", 1'b1, alert_wire_n)
        `PULSE(watchdog_fault_evt, 1'b1);
        wd = 1;
        for (int i = 0; i < 8; i += 5) rd(`CMD_MFR_STATUS, i, st(i));
        `PULSE(clear_faults, 1'b1);
        wd = 0;
        stk[6] = 8'h00;
        rd(`CMD_MFR_STATUS, 6, st(6));
        `CHK("alert clear", 1'b1, alert_wire_n)
        repeat (3) @(posedge clk);
        // A silent design must not pass on the alert checks alone
        `CHK("pending", 0, q.size())
        conclude();
    end
endmodule // mfr_status_telemetry_test
`default_nettype wire
